// ### rtl/mbp_defines.svh
// Purpose: Constants of the memory-bus pin-function block.
// Assumes: Included by its bare name from the package and the design file.
// Notes: Active-low strobes idle at 1; masks idle at 1 (lane masked).
`ifndef MBP_DEFINES_SVH
`define MBP_DEFINES_SVH

// =====================================================================
// Configuration codes
// DRAM-type code that moves the area 2 row strobe onto the endian pin
`define MBP_DRAM_TYPE_SELECT_AREA2_DRAM 3'b101
// Area numbers with card-interface option, and the area that can take the second DRAM row strobe
`define MBP_AREA_CARD_A 3'h5
`define MBP_AREA_CARD_B 3'h6
`define MBP_AREA_DRAM2 3'h2

// =====================================================================
// Reset values
`define MBP_RST_CS 7'h7f
`define MBP_RST_STROBE 1'b1
`define MBP_RST_MASK 4'hf
`define MBP_RST_WIDTH 2'h0
`define MBP_RST_ENDIAN 1'b0

// =====================================================================
// Timing: cycles after reset release before pin straps are taken
// (two synchroniser stages must first fill)
`define MBP_STRAP_DELAY 2'h2

// =====================================================================
// Field positions on the data pins
`define MBP_PORT_LSB 16
`define MBP_PORT_MSB 23
`define MBP_TOP_LSB 24
`define MBP_TOP_MSB 31

`endif

// ### rtl/mbp_pkg.sv
// Purpose: Types of the memory-bus pin-function block.
// Assumes: Shared constants live in mbp_defines.svh.
// Notes: Memory type is supplied per access by the bus state logic.
`include "mbp_defines.svh"

package mbp_pkg;

	// Memory interface kind of the access in progress
	typedef enum logic [2:0]
	{
		MEM_NORMAL = 3'b000,
		MEM_DRAM = 3'b001,
		MEM_SDRAM = 3'b010,
		MEM_PSRAM = 3'b011,
		MEM_CARD = 3'b100
	} mbp_mem_type;

	// Ownership of the external bus
	typedef enum logic
	{
		BUS_OWNED = 1'b0,
		BUS_RELEASED = 1'b1
	} mbp_bus_state_type;

endpackage

// ### rtl/mbp_pin_function.sv
// Purpose: Maps internal access phases onto the shared memory-bus pins.
// Assumes: Access phase inputs come from bus state logic on ref_clk.
// Notes: Every pin output is registered, so pins lag the phases by one cycle.
`include "mbp_defines.svh"

module mbp_pin_function
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Configuration bits
	input wire logic portFunctionEnable,
	input wire logic [7:0] sharedPortDir,
	input wire logic [7:0] sharedPortOut,
	input wire logic area5CardEnable,
	input wire logic area6CardEnable,
	input wire logic [2:0] dramTypeSelect,
	// Access phases from bus state logic
	input wire logic accActive,
	input wire logic accBeat,
	input wire logic [2:0] accArea,
	input wire mbp_pkg::mbp_mem_type accMemType,
	input wire logic accWrite,
	input wire logic [3:0] accLaneEn,
	input wire logic accRowPhase,
	input wire logic accColPhase,
	input wire logic accStrobePhase,
	input wire logic accIoCycle,
	input wire logic psramRefresh,
	input wire logic sdramClockEnable,
	input wire logic [31:0] accWriteData,
	input wire logic accDataDrive,
	// Pins
	output logic busCycleStartN,
	output logic [6:0] areaChipSelectsN,
	output logic readWriteN,
	output logic rowStrobeN,
	output logic colStrobeLane0N,
	output logic colStrobeLane1N,
	output logic colStrobeLane2N,
	output logic colStrobeLane3N,
	output logic lane0MaskOrWriteN,
	output logic lane1MaskOrWriteN,
	output logic lane2MaskOrWriteN,
	output logic lane3MaskOrWriteN,
	output logic readStrobeN,
	output logic clockEnable,
	output logic busReleaseAckN,
	input wire logic waitN,
	input wire logic cardIo16BitN,
	input wire logic busReleaseRequestN,
	input wire logic [31:0] dataPinIn,
	output logic [31:0] dataPinOut,
	output logic [31:0] dataPinOe,
	input wire logic widthMode0In,
	output logic cardAEnableHighN,
	output logic widthMode0Oe,
	input wire logic widthMode1In,
	output logic cardBEnableHighN,
	output logic widthMode1Oe,
	input wire logic endianModeIn,
	output logic area2RowStrobeN,
	output logic endianModeOe,
	// Status toward the bus state logic
	output logic waitRequest,
	output logic cardIo16Bit,
	output logic busReleased,
	output logic [1:0] area0Width,
	output logic littleEndian,
	output logic [31:0] readData,
	output logic [7:0] sharedPortIn
);
	import mbp_pkg::*;

	// =================================================================
	// Input synchronisers
	logic [35:0] pinMeta_q;
	logic [35:0] pinSync_q;
	logic waitSync;
	logic io16Sync;
	logic breqSync;
	logic [31:0] dataSync;

	// Two stages on every pin input; first stage feeds only the second
	always_ff @(posedge ref_clk)
	begin
		pinMeta_q <= {waitN, cardIo16BitN, busReleaseRequestN, endianModeIn, dataPinIn};
		pinSync_q <= pinMeta_q;
	end

	assign waitSync = ~pinSync_q[35];
	assign io16Sync = ~pinSync_q[34];
	assign breqSync = ~pinSync_q[33];
	assign dataSync = pinSync_q[31:0];

	logic [1:0] modeMeta_q;
	logic [1:0] modeSync_q;

	// Width-mode straps synchronised like any other pin
	always_ff @(posedge ref_clk)
	begin
		modeMeta_q <= {widthMode1In, widthMode0In};
		modeSync_q <= modeMeta_q;
	end

	// =================================================================
	// Strap capture after reset release
	logic [1:0] strapCnt_q;
	logic strapDone_q;
	logic littleEndian_q;
	logic [1:0] area0Width_q;

	// Straps are taken once the synchronisers hold post-reset levels
	// Strap capture
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			strapCnt_q <= 2'h0;
			strapDone_q <= 1'b0;
			littleEndian_q <= `MBP_RST_ENDIAN;
			area0Width_q <= `MBP_RST_WIDTH;
		end
		else if (!strapDone_q)
		begin
			if (strapCnt_q == `MBP_STRAP_DELAY)
			begin
				strapDone_q <= 1'b1;
				littleEndian_q <= pinSync_q[32];
				area0Width_q <= modeSync_q;
			end
			else
			begin
				strapCnt_q <= strapCnt_q + 2'h1;
			end
		end
	end

	// =================================================================
	// Bus release handshake
	mbp_bus_state_type busState_q;

	// Grant only between accesses so no cycle is cut short
	// Release handshake
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			busState_q <= BUS_OWNED;
		end
		else
		begin
			case (busState_q)
				BUS_OWNED:
				begin
					if (breqSync && !accActive)
					begin
						busState_q <= BUS_RELEASED;
					end
				end
				BUS_RELEASED:
				begin
					if (!breqSync)
					begin
						busState_q <= BUS_OWNED;
					end
				end
				default:
				begin
					busState_q <= BUS_OWNED;
				end
			endcase
		end
	end

	// =================================================================
	// Per-access decode
	logic run;
	logic isDram;
	logic isSdram;
	logic isPsram;
	logic isCard;
	logic area2Split;
	logic onArea2;
	logic [6:0] csD;
	logic [3:0] colD;
	logic [3:0] laneD;
	logic rowD;
	logic row2D;
	logic ce2aD;
	logic ce2bD;

	assign run = accActive && (busState_q == BUS_OWNED);
	assign isDram = accMemType == MEM_DRAM;
	assign isSdram = accMemType == MEM_SDRAM;
	assign isPsram = accMemType == MEM_PSRAM;
	assign isCard = accMemType == MEM_CARD;
	assign area2Split = dramTypeSelect == `MBP_DRAM_TYPE_SELECT_AREA2_DRAM;
	assign onArea2 = accArea == `MBP_AREA_DRAM2;

	// Strobe and select next values; all active low
	always_comb
	begin
		csD = `MBP_RST_CS;
		colD = 4'hf;
		laneD = `MBP_RST_MASK;
		rowD = 1'b1;
		row2D = 1'b1;
		ce2aD = 1'b1;
		ce2bD = 1'b1;
		if (run)
		begin
			// Card enable-1 on the select, enable-2 on high byte
			if (accArea <= 3'h6 && (!isCard || accLaneEn[0]))
			begin
				csD[accArea] = 1'b0;
			end
			ce2aD = !(isCard && accArea == `MBP_AREA_CARD_A && accLaneEn[1]);
			ce2bD = !(isCard && accArea == `MBP_AREA_CARD_B && accLaneEn[1]);
			// RAS, CE, or area 2 RAS on the endian pin
			if (isPsram)
			begin
				rowD = 1'b0;
			end
			else if ((isDram || isSdram) && accRowPhase)
			begin
				if (area2Split && onArea2)
				begin
					row2D = 1'b0;
				end
				else
				begin
					rowD = 1'b0;
				end
			end
			if (isSdram)
			begin
				colD[0] = !accColPhase;
			end
			else if (isPsram)
			begin
				colD[0] = !(accStrobePhase && !accWrite);
			end
			else if (isDram && accColPhase)
			begin
				if (area2Split && onArea2)
				begin
					colD[2] = !accLaneEn[0];
					colD[3] = !accLaneEn[1];
				end
				else
				begin
					colD = ~accLaneEn;
				end
			end
			if (isSdram)
			begin
				laneD = ~accLaneEn;
			end
			else if (isCard)
			begin
				laneD[1] = !(accStrobePhase && accWrite && !accIoCycle);
				laneD[2] = !(accStrobePhase && !accWrite && accIoCycle);
				laneD[3] = !(accStrobePhase && accWrite && accIoCycle);
			end
			else if (accStrobePhase && accWrite)
			begin
				laneD = ~accLaneEn;
			end
		end
		// Refresh of pseudo-SRAM uses the output-enable pin with no access
		if (psramRefresh)
		begin
			colD[0] = 1'b0;
		end
	end

	// =================================================================
	// Strobe registers
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			areaChipSelectsN <= `MBP_RST_CS;
			busCycleStartN <= `MBP_RST_STROBE;
			readWriteN <= `MBP_RST_STROBE;
			readStrobeN <= `MBP_RST_STROBE;
			rowStrobeN <= `MBP_RST_STROBE;
			area2RowStrobeN <= `MBP_RST_STROBE;
			{colStrobeLane3N, colStrobeLane2N, colStrobeLane1N, colStrobeLane0N} <= 4'hf;
			{lane3MaskOrWriteN, lane2MaskOrWriteN, lane1MaskOrWriteN, lane0MaskOrWriteN}
				<= `MBP_RST_MASK;
			cardAEnableHighN <= `MBP_RST_STROBE;
			cardBEnableHighN <= `MBP_RST_STROBE;
			clockEnable <= 1'b0;
		end
		else
		begin
			areaChipSelectsN <= csD;
			// Beat pulse per cycle start and burst data cycle
			busCycleStartN <= !(run && accBeat);
			readWriteN <= !(run && accWrite);
			// Read strobe
			// Card I/O reads use their own strobe; card memory reads still use this one
			readStrobeN <= !(run && !accWrite && accStrobePhase && !(isCard && accIoCycle));
			rowStrobeN <= rowD;
			area2RowStrobeN <= row2D;
			{colStrobeLane3N, colStrobeLane2N, colStrobeLane1N, colStrobeLane0N} <= colD;
			{lane3MaskOrWriteN, lane2MaskOrWriteN, lane1MaskOrWriteN, lane0MaskOrWriteN}
				<= laneD;
			cardAEnableHighN <= ce2aD;
			cardBEnableHighN <= ce2bD;
			clockEnable <= sdramClockEnable;
		end
	end

	// =================================================================
	// Dual-purpose pin directions
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			widthMode0Oe <= 1'b0;
			widthMode1Oe <= 1'b0;
			endianModeOe <= 1'b0;
		end
		else
		begin
			// Card-enable-2 outputs only with card mode set
			widthMode0Oe <= area5CardEnable;
			widthMode1Oe <= area6CardEnable;
			// Endian pin turns output only for code 101
			endianModeOe <= area2Split;
		end
	end

	// =================================================================
	// Data pins and shared port
	logic [31:0] oeD;
	logic [31:0] outD;

	// Port bits keep their own direction even while memory cycles run
	always_comb
	begin
		outD = accWriteData;
		oeD = {32{run && accWrite && accDataDrive}};
		if (portFunctionEnable)
		begin
			outD[`MBP_PORT_MSB:`MBP_PORT_LSB] = sharedPortOut;
			oeD[`MBP_PORT_MSB:`MBP_PORT_LSB] = sharedPortDir;
			outD[`MBP_TOP_MSB:`MBP_TOP_LSB] = 8'h00;
			oeD[`MBP_TOP_MSB:`MBP_TOP_LSB] = 8'h00;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			dataPinOut <= 32'h0000_0000;
			dataPinOe <= 32'h0000_0000;
			readData <= 32'h0000_0000;
			sharedPortIn <= 8'h00;
		end
		else
		begin
			dataPinOut <= outD;
			dataPinOe <= oeD;
			readData <= portFunctionEnable ? {16'h0000, dataSync[15:0]} : dataSync;
			sharedPortIn <= dataSync[`MBP_PORT_MSB:`MBP_PORT_LSB];
		end
	end

	// =================================================================
	// Status toward the bus state logic
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			waitRequest <= 1'b0;
			cardIo16Bit <= 1'b0;
			busReleased <= 1'b0;
			busReleaseAckN <= 1'b1;
		end
		else
		begin
			// Wait request as a synchronous level
			waitRequest <= waitSync;
			cardIo16Bit <= io16Sync && littleEndian_q;
			busReleased <= busState_q == BUS_RELEASED;
			busReleaseAckN <= busState_q != BUS_RELEASED;
		end
	end

	assign area0Width = area0Width_q;
	assign littleEndian = littleEndian_q;

endmodule

// ### dv/mbp_pin_function_sva.sv
// Purpose: Port-level checks of the memory-bus pin mapping.
// Assumes: Bound to mbp_pin_function; one clock domain.
// Notes: Access checks hold only while the bus is owned.
module mbp_pin_function_sva
	import mbp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic portFunctionEnable,
	input wire logic [7:0] sharedPortDir,
	input wire logic area5CardEnable,
	input wire logic area6CardEnable,
	input wire logic [2:0] dramTypeSelect,
	input wire logic accActive,
	input wire logic accBeat,
	input wire logic [2:0] accArea,
	input wire mbp_pkg::mbp_mem_type accMemType,
	input wire logic [3:0] accLaneEn,
	input wire logic busCycleStartN,
	input wire logic [6:0] areaChipSelectsN,
	input wire logic lane0MaskOrWriteN,
	input wire logic lane1MaskOrWriteN,
	input wire logic lane2MaskOrWriteN,
	input wire logic lane3MaskOrWriteN,
	input wire logic busReleaseAckN,
	input wire logic busReleaseRequestN,
	input wire logic [31:0] dataPinOe,
	input wire logic widthMode0Oe,
	input wire logic widthMode1Oe,
	input wire logic endianModeOe,
	input wire logic cardAEnableHighN,
	input wire logic cardIo16Bit,
	input wire logic busReleased,
	input wire logic littleEndian
);
	timeunit 1ns;
	timeprecision 100ps;
	// =========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// Access taken only while the bus is ours
	wire logic busOwn = accActive && !busReleased;
	sequence s_relReq;
		(!busReleaseRequestN && !accActive) [*4];
	endsequence
	property p_cs;
		busOwn && accMemType == MEM_NORMAL |=> areaChipSelectsN == ~(7'h01 << $past(accArea));
	endproperty
	a_cs: assert property (p_cs) else $error("chip select wrong");
	property p_bcs;
		busOwn && accBeat |=> !busCycleStartN;
	endproperty
	a_bcs: assert property (p_bcs) else $error("cycle start missing");
	property p_mask;
		busOwn && accMemType == MEM_SDRAM |=> {lane3MaskOrWriteN, lane2MaskOrWriteN,
			lane1MaskOrWriteN, lane0MaskOrWriteN} == ~$past(accLaneEn);
	endproperty
	a_mask: assert property (p_mask) else $error("lane mask wrong");
	property p_port;
		portFunctionEnable |=> dataPinOe[31:16] == {8'h00, $past(sharedPortDir)};
	endproperty
	a_port: assert property (p_port) else $error("port lane enables wrong");
	property p_modeOe;
		1'b1 |=> {widthMode0Oe, widthMode1Oe, endianModeOe} == {$past(area5CardEnable),
			$past(area6CardEnable), $past(dramTypeSelect) == 3'h5};
	endproperty
	a_modeOe: assert property (p_modeOe) else $error("mode pin enable wrong");
	property p_ce2;
		busOwn && accMemType == MEM_CARD && accArea == 3'h5 && area5CardEnable && accLaneEn[1]
			|=> !cardAEnableHighN;
	endproperty
	a_ce2: assert property (p_ce2) else $error("card enable two missing");
	property p_rel;
		s_relReq |=> !busReleaseAckN && busReleased;
	endproperty
	a_rel: assert property (p_rel) else $error("release not granted");
	property p_io16;
		!littleEndian |-> !cardIo16Bit;
	endproperty
	a_io16: assert property (p_io16) else $error("16-bit flag used big-endian");
endmodule

bind mbp_pin_function mbp_pin_function_sva u_sva (.ref_clk, .sys_rst, .portFunctionEnable,
	.sharedPortDir, .area5CardEnable, .area6CardEnable, .dramTypeSelect, .accActive, .accBeat,
	.accArea, .accMemType, .accLaneEn, .busCycleStartN, .areaChipSelectsN, .lane0MaskOrWriteN,
	.lane1MaskOrWriteN, .lane2MaskOrWriteN, .lane3MaskOrWriteN, .busReleaseAckN,
	.busReleaseRequestN, .dataPinOe, .widthMode0Oe, .widthMode1Oe, .endianModeOe,
	.cardAEnableHighN, .cardIo16Bit, .busReleased, .littleEndian);

// ### dv/mbp_far_side.sv
// Purpose: Far side: memory data lanes, strap resistors, card flag.
// Assumes: Controls change just after a ref_clk edge.
// Notes: Undriven data lanes show memData while memDrive is set, else the inverse of their last level.
module mbp_far_side
(
	input wire logic ref_clk,
	input wire logic [31:0] dataPinOut,
	input wire logic [31:0] dataPinOe,
	input wire logic cardAEnableHighN,
	input wire logic widthMode0Oe,
	input wire logic cardBEnableHighN,
	input wire logic widthMode1Oe,
	input wire logic area2RowStrobeN,
	input wire logic endianModeOe,
	input wire logic strapEndian,
	input wire logic [1:0] strapWidth,
	input wire logic io16N,
	input wire logic memDrive,
	input wire logic [31:0] memData,
	output logic cardIo16BitN,
	output logic [31:0] dataPinIn,
	output logic widthMode0In,
	output logic widthMode1In,
	output logic endianModeIn
);
	timeunit 1ns;
	timeprecision 100ps;
	// =========================================================
	// Pin levels
	logic [31:0] lastQ;
	// Keeps a floating lane from passing for a stale value
	always_ff @(posedge ref_clk)
		lastQ <= dataPinIn;
	assign dataPinIn = (dataPinOe & dataPinOut) | (~dataPinOe & (memDrive ? memData : ~lastQ));
	assign widthMode0In = widthMode0Oe ? cardAEnableHighN : strapWidth[0];
	assign widthMode1In = widthMode1Oe ? cardBEnableHighN : strapWidth[1];
	assign endianModeIn = endianModeOe ? area2RowStrobeN : strapEndian;
	assign cardIo16BitN = strapEndian ? io16N : 1'b0;
endmodule

// ### dv/tb_mbp_pin_function.sv
// Purpose: Self-checking bench of the memory-bus pin mapping.
// Assumes: 25 MHz ref_clk, synchronous reset held 16 cycles.
// Notes: Pins are registered, so checks land one edge after a request.
module tb_mbp_pin_function;
	timeunit 1ns;
	timeprecision 100ps;
	import mbp_pkg::*;
	logic ref_clk, sys_rst, portFunctionEnable, area5CardEnable, area6CardEnable, psramRefresh;
	logic [7:0] sharedPortDir, sharedPortOut, sharedPortIn;
	logic [2:0] dramTypeSelect, accArea;
	mbp_mem_type accMemType;
	logic accActive, accBeat, accWrite, accRowPhase, accColPhase, accStrobePhase, accIoCycle;
	logic sdramClockEnable, accDataDrive, strapEndian, io16N, memDrive;
	logic [3:0] accLaneEn;
	logic [31:0] accWriteData, dataPinIn, dataPinOut, dataPinOe, readData, memData;
	logic busCycleStartN, readWriteN, rowStrobeN, readStrobeN, clockEnable, busReleaseAckN;
	logic [6:0] areaChipSelectsN;
	logic colStrobeLane0N, colStrobeLane1N, colStrobeLane2N, colStrobeLane3N;
	logic lane0MaskOrWriteN, lane1MaskOrWriteN, lane2MaskOrWriteN, lane3MaskOrWriteN;
	logic waitN, cardIo16BitN, busReleaseRequestN, widthMode0In, widthMode1In, endianModeIn;
	logic cardAEnableHighN, widthMode0Oe, cardBEnableHighN, widthMode1Oe, area2RowStrobeN;
	logic endianModeOe, waitRequest, cardIo16Bit, busReleased, littleEndian;
	logic [1:0] area0Width, strapWidth;
	logic [2:0] cA [3] = '{3'h5, 3'h6, 3'h5};
	logic cW [3] = '{1'b1, 1'b0, 1'b1};
	logic [3:0] cP [3] = '{4'h4, 4'hc, 4'hc};
	logic [3:0] cL [3] = '{4'hd, 4'hb, 4'h7};
	logic [1:0] cE [3] = '{2'h2, 2'h1, 2'h2};
	int failures, cmp_count;
	mbp_pin_function u_dut (.*);
	mbp_far_side u_far (.*);
	// =========================================================
	// Clock and helpers
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Holds the request; back-to-back calls form a burst
	task automatic acc(input logic [2:0] a, input mbp_mem_type t, input logic w,
		input logic [3:0] l, input logic [3:0] ph);
		{accActive, accBeat, accArea, accWrite, accLaneEn} = {2'b11, a, w, l};
		accMemType = t;
		{accIoCycle, accStrobePhase, accColPhase, accRowPhase} = ph;
		step(1);
	endtask
	function automatic logic [3:0] lanes();
		return {lane3MaskOrWriteN, lane2MaskOrWriteN, lane1MaskOrWriteN, lane0MaskOrWriteN};
	endfunction
	function automatic logic [3:0] cols();
		return {colStrobeLane3N, colStrobeLane2N, colStrobeLane1N, colStrobeLane0N};
	endfunction
	task automatic reset(input logic e, input logic [1:0] wd);
		{strapEndian, strapWidth, sys_rst} = {e, wd, 1'b1};
		// Card-enable configuration resets too, so the width-mode pins are inputs while straps are read
		{area5CardEnable, area6CardEnable} = 2'h0;
		step(16);
		sys_rst = 1'b0;
		step(5);
		check("littleEndian", littleEndian, e);
		check("area0Width", area0Width, wd);
	endtask
	task automatic waitAck(input logic v);
		for (int i = 0; i < 12 && busReleaseAckN !== v; i++)
			step(1);
	endtask
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Cuts a hang short
	initial
	begin
		#120000;
		failures++;
		finish_test();
	end
	// =========================================================
	// Tests
	initial
	begin
		{portFunctionEnable, area5CardEnable, area6CardEnable, psramRefresh} = 4'h0;
		{sdramClockEnable, accDataDrive, accActive, accBeat, accWrite, memDrive} = 6'h00;
		{accRowPhase, accColPhase, accStrobePhase, accIoCycle, accArea} = 7'h00;
		{sharedPortDir, sharedPortOut, accLaneEn, dramTypeSelect} = 23'h0;
		{waitN, busReleaseRequestN, io16N} = 3'h7;
		accMemType = MEM_NORMAL;
		accWriteData = 32'h1357_9bdf;
		memData = 32'h5a3c_9e18;
		reset(1'b0, 2'h1);
		check("io16 big", cardIo16Bit, 1'b0);
		check("mode oe", {widthMode1Oe, widthMode0Oe, endianModeOe}, 3'h0);
		accDataDrive = 1'b1;
		for (int a = 0; a < 7; a++)
		begin
			acc(a[2:0], MEM_NORMAL, 1'b1, 4'h3, 4'h4);
			check("cs", areaChipSelectsN, 7'h7f ^ (7'h01 << a));
			check("bcs", busCycleStartN, 1'b0);
			check("rw", {readWriteN, readStrobeN}, 2'h1);
			check("we", lanes(), 4'hc);
		end
		check("data oe", dataPinOe, 32'hffff_ffff);
		check("data out", dataPinOut, accWriteData);
		accDataDrive = 1'b0;
		acc(3'h1, MEM_NORMAL, 1'b0, 4'hf, 4'h4);
		check("rd", {readWriteN, readStrobeN, lanes()}, 6'h2f);
		sdramClockEnable = 1'b1;
		acc(3'h3, MEM_SDRAM, 1'b1, 4'h5, 4'h2);
		check("sd col", {lanes(), colStrobeLane0N, rowStrobeN}, 6'h29);
		check("cke", clockEnable, 1'b1);
		acc(3'h3, MEM_SDRAM, 1'b0, 4'h5, 4'h1);
		check("sd ras", rowStrobeN, 1'b0);
		acc(3'h3, MEM_DRAM, 1'b0, 4'h6, 4'h1);
		check("dr ras", rowStrobeN, 1'b0);
		acc(3'h3, MEM_DRAM, 1'b0, 4'h6, 4'h2);
		check("dr cas", cols(), 4'h9);
		dramTypeSelect = 3'h5;
		acc(3'h2, MEM_DRAM, 1'b0, 4'h3, 4'h1);
		check("a2 ras", {area2RowStrobeN, rowStrobeN, endianModeOe}, 3'h3);
		acc(3'h2, MEM_DRAM, 1'b0, 4'h3, 4'h2);
		check("a2 cas", cols(), 4'h3);
		dramTypeSelect = 3'h0;
		acc(3'h3, MEM_PSRAM, 1'b0, 4'hf, 4'h4);
		check("ps", {rowStrobeN, colStrobeLane0N}, 2'h0);
		{accActive, psramRefresh} = 2'h1;
		step(1);
		check("refresh", {colStrobeLane0N, rowStrobeN}, 2'h1);
		psramRefresh = 1'b0;
		{area5CardEnable, area6CardEnable} = 2'h3;
		for (int i = 0; i < 3; i++)
		begin
			acc(cA[i], MEM_CARD, cW[i], 4'h3, cP[i]);
			check("card lanes", lanes(), cL[i]);
			check("card cs", areaChipSelectsN, 7'h7f ^ (7'h01 << cA[i]));
			check("ce2", {cardBEnableHighN, cardAEnableHighN}, cE[i]);
		end
		check("card oe", {widthMode1Oe, widthMode0Oe}, 2'h3);
		{accActive, accBeat, portFunctionEnable, memDrive} = 4'h3;
		{sharedPortDir, sharedPortOut} = 16'ha5f0;
		step(4);
		check("port oe", dataPinOe[31:16], 16'h00a5);
		check("port in", sharedPortIn, 8'hb8);
		check("rd top", readData[31:16], 16'h0);
		portFunctionEnable = 1'b0;
		waitN = 1'b0;
		step(4);
		check("wait on", waitRequest, 1'b1);
		check("rd data", readData, memData);
		waitN = 1'b1;
		step(4);
		check("wait off", waitRequest, 1'b0);
		busReleaseRequestN = 1'b0;
		waitAck(1'b0);
		check("back", {busReleaseAckN, busReleased}, 2'h1);
		acc(3'h1, MEM_NORMAL, 1'b1, 4'hf, 4'h4);
		check("refused", areaChipSelectsN, 7'h7f);
		{accActive, accBeat, busReleaseRequestN} = 3'h1;
		waitAck(1'b1);
		check("back off", {busReleaseAckN, busReleased}, 2'h2);
		reset(1'b1, 2'h2);
		io16N = 1'b0;
		step(4);
		check("io16 little", cardIo16Bit, 1'b1);
		finish_test();
	end
endmodule
